//--- core/ifm_decode.v
`timescale 1ns/10ps
`default_nettype none
// One-hot decode of a function code into the 38 function slots
module ifm_decode #(
	parameter NFUNC = 38
) (
	// Code and qualifier
	input wire [5:0] code,
	input wire act,
	// One-hot result, bit 0 unused (no function)
	output reg [NFUNC-1:0] onehot
);
	integer i;
	// Code 0 maps nowhere; out-of-range codes map nowhere
	always @* begin
		onehot = {NFUNC{1'b0}};
		for (i = 1; i < NFUNC; i = i + 1) begin
			if (code == i[5:0])
				onehot[i] = act;
		end
	end
endmodule // ifm_decode
`default_nettype wire

//--- core/ifm_map.vh
`ifndef IFM_MAP_VH
`define IFM_MAP_VH
// Register byte offsets
`define IFM_MASK_HIGH_OFF 8'h00
`define IFM_SEL_ONE_OFF 8'h04
`define IFM_CTRL_OFF 8'h08
`define IFM_STATUS_OFF 8'h0C
`define IFM_TERM_SEL_OFF 8'h10
// Reset values
`define IFM_MASK_HIGH_RST 16'h0000
`define IFM_SEL_ONE_RST 6'h0E
`define IFM_TERM_SEL_RST 6'h00
// Function code limits and decoded codes
`define IFM_CODE_MAX 6'h25
`define IFM_CODE_NONE 6'h00
`define IFM_CODE_SERVO_EN 6'h01
`define IFM_CODE_FAULT_RST 6'h02
`define IFM_CODE_FWD_LIMIT 6'h0E
`define IFM_CODE_HALT 6'h22
`define IFM_CODE_CLR_DEV 6'h23
`define IFM_CODE_PULSE_BLK 6'h25
// Mask covers functions 17 to 32
`define IFM_MASK_BASE 6'h11
// Control register fields
`define IFM_CTRL_T1_POL 0
`define IFM_CTRL_T2_POL 1
// Status register fields
`define IFM_STAT_DUP 0
`define IFM_STAT_RUN 1
`define IFM_STAT_REJ 2
// Bus responses
`define IFM_RESP_OKAY 2'h0
`define IFM_RESP_SLVERR 2'h2
`endif

//--- core/ifm_mapper.v
// Behaviour
// - 16-bit mask forces functions 17..32 at power-up
// - Assigned terminal's logic overrides mask bit
// - Terminal one selector 0..37, resets to 14
// - Decode none, servo, reset, halt, clear, block
// - Mask stored binary; decimal or hex is presentation
// - Duplicate terminal assignment raises configuration error
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ifm_map.vh"
module ifm_mapper #(
	parameter NFUNC = 38
) (
	// Clock, reset, enable
	input wire mclk,
	input wire reset,
	input wire ce,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Input terminal pins and drive state
	input wire input_terminal_one,
	input wire input_terminal_two,
	input wire drive_running,
	// Function outputs
	output reg [NFUNC-1:0] func_active,
	output reg servo_enable,
	output reg fault_warning_reset,
	output reg forward_limit_switch,
	output reg emergency_halt,
	output reg clear_position_deviation,
	output reg pulse_input_block,
	output reg duplicate_assignment_error
);
	// Synchronised pins
	wire t1_sync;
	wire t2_sync;
	wire run_sync;
	ifm_sync u_sync_t1 (.mclk(mclk), .reset(reset), .ce(ce), .din(input_terminal_one),
		.dout(t1_sync));
	ifm_sync u_sync_t2 (.mclk(mclk), .reset(reset), .ce(ce), .din(input_terminal_two),
		.dout(t2_sync));
	ifm_sync u_sync_run (.mclk(mclk), .reset(reset), .ce(ce), .din(drive_running),
		.dout(run_sync));

	// Software-visible registers
	// Stored mask stands in for non-volatile storage: given its default once, kept through reset
	reg [15:0] power_on_function_mask_high_r = `IFM_MASK_HIGH_RST;
	reg [15:0] mask_live_r; // Mask latched once after reset release
	reg mask_loaded_r; // Latch done flag
	reg [5:0] terminal_one_function_select_r; // Terminal one code
	reg [5:0] term_two_select_r; // Terminal two code, used for duplicate check
	reg [1:0] ctrl_r; // Terminal polarity (1 = active high)
	reg reject_r; // Sticky: a selection write was refused
	reg reject_nxt;

	// Write channel capture, address and data may arrive in either order
	reg aw_have_r;
	reg w_have_r;
	reg [7:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	wire wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;

	// Write decode
	wire wr_mask = wr_go & (aw_addr_r == `IFM_MASK_HIGH_OFF);
	wire wr_sel1 = wr_go & (aw_addr_r == `IFM_SEL_ONE_OFF);
	wire wr_ctrl = wr_go & (aw_addr_r == `IFM_CTRL_OFF);
	wire wr_stat = wr_go & (aw_addr_r == `IFM_STATUS_OFF);
	wire wr_sel2 = wr_go & (aw_addr_r == `IFM_TERM_SEL_OFF);
	wire wr_hit = wr_mask | wr_sel1 | wr_ctrl | wr_stat | wr_sel2;
	// Selection writes refused while running or out of range
	wire sel_ok = ~run_sync & (w_data_r[5:0] <= `IFM_CODE_MAX) & (w_data_r[15:6] == 10'h000)
		& w_strb_r[0];

	// Write address and data handshake
	always @(posedge mclk) begin
		if (reset) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `IFM_RESP_OKAY;
		end else if (ce) begin
			// Ready only while the slot is empty, so one write is held at a time
			s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			// Both halves present: commit and respond
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `IFM_RESP_OKAY : `IFM_RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Sticky reject flag: a new refusal wins over a clear
	always @* begin
		reject_nxt = reject_r;
		if (wr_stat & w_strb_r[0] & w_data_r[`IFM_STAT_REJ])
			reject_nxt = 1'b0;
		if ((wr_sel1 | wr_sel2) & ~sel_ok)
			reject_nxt = 1'b1;
	end

	// Register file writes
	always @(posedge mclk) begin
		if (reset) begin
			// Mask is left alone so a reset acts as the power cycle that applies it
			terminal_one_function_select_r <= `IFM_SEL_ONE_RST;
			term_two_select_r <= `IFM_TERM_SEL_RST;
			ctrl_r <= 2'b11;
			reject_r <= 1'b0;
		end else if (ce) begin
			reject_r <= reject_nxt;
			// Mask is plain binary; decimal or hex is only how tools show it
			if (wr_mask) begin
				if (w_strb_r[0])
					power_on_function_mask_high_r[7:0] <= w_data_r[7:0];
				if (w_strb_r[1])
					power_on_function_mask_high_r[15:8] <= w_data_r[15:8];
			end
			// Selection accepted only while stopped and in range
			if (wr_sel1 & sel_ok)
				terminal_one_function_select_r <= w_data_r[5:0];
			if (wr_sel2 & sel_ok)
				term_two_select_r <= w_data_r[5:0];
			if (wr_ctrl & w_strb_r[0])
				ctrl_r <= w_data_r[1:0];
		end
	end

	// Mask snapshot: the stored mask is not reset, so the value written
	// before a reset becomes live after it, standing in for a power cycle
	always @(posedge mclk) begin
		if (reset) begin
			mask_loaded_r <= 1'b0;
			mask_live_r <= 16'h0000;
		end else if (ce & ~mask_loaded_r) begin
			mask_loaded_r <= 1'b1;
			mask_live_r <= power_on_function_mask_high_r;
		end
	end

	// Terminal levels after polarity
	wire t1_act = t1_sync ~^ ctrl_r[`IFM_CTRL_T1_POL];
	wire t2_act = t2_sync ~^ ctrl_r[`IFM_CTRL_T2_POL];

	// Decode each terminal onto the function slots
	wire [NFUNC-1:0] t1_hot;
	wire [NFUNC-1:0] t2_hot;
	wire [NFUNC-1:0] t1_own;
	wire [NFUNC-1:0] t2_own;
	ifm_decode #(.NFUNC(NFUNC)) u_dec_t1 (.code(terminal_one_function_select_r), .act(t1_act),
		.onehot(t1_hot));
	ifm_decode #(.NFUNC(NFUNC)) u_dec_t2 (.code(term_two_select_r), .act(t2_act),
		.onehot(t2_hot));
	ifm_decode #(.NFUNC(NFUNC)) u_own_t1 (.code(terminal_one_function_select_r), .act(1'b1),
		.onehot(t1_own));
	ifm_decode #(.NFUNC(NFUNC)) u_own_t2 (.code(term_two_select_r), .act(1'b1),
		.onehot(t2_own));

	// Mask spread onto slots 17..32, forced active when set
	wire [NFUNC-1:0] mask_slots = {{(NFUNC-33){1'b0}}, mask_live_r, 17'h00000};
	wire [NFUNC-1:0] owned = t1_own | t2_own;
	// Owned slots follow their terminal, others follow the mask
	wire [NFUNC-1:0] func_nxt = (t1_hot | t2_hot) | (mask_slots & ~owned);
	// Two terminals on one real function is a configuration error
	wire dup_nxt = (terminal_one_function_select_r == term_two_select_r)
		& (terminal_one_function_select_r != `IFM_CODE_NONE);

	// Registered function outputs
	always @(posedge mclk) begin
		if (reset) begin
			func_active <= {NFUNC{1'b0}};
			servo_enable <= 1'b0;
			fault_warning_reset <= 1'b0;
			forward_limit_switch <= 1'b0;
			emergency_halt <= 1'b0;
			clear_position_deviation <= 1'b0;
			pulse_input_block <= 1'b0;
			duplicate_assignment_error <= 1'b0;
		end else if (ce) begin
			func_active <= func_nxt;
			servo_enable <= func_nxt[`IFM_CODE_SERVO_EN];
			fault_warning_reset <= func_nxt[`IFM_CODE_FAULT_RST];
			forward_limit_switch <= func_nxt[`IFM_CODE_FWD_LIMIT];
			emergency_halt <= func_nxt[`IFM_CODE_HALT];
			clear_position_deviation <= func_nxt[`IFM_CODE_CLR_DEV];
			pulse_input_block <= func_nxt[`IFM_CODE_PULSE_BLK];
			duplicate_assignment_error <= dup_nxt;
		end
	end

	// Read channel: one read at a time, answer one cycle after address
	always @(posedge mclk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `IFM_RESP_OKAY;
		end else if (ce) begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `IFM_RESP_OKAY;
				case ({s_axi_araddr[7:2], 2'b00})
					`IFM_MASK_HIGH_OFF: s_axi_rdata <= {16'h0000, power_on_function_mask_high_r};
					`IFM_SEL_ONE_OFF: s_axi_rdata <= {26'h0000000, terminal_one_function_select_r};
					`IFM_CTRL_OFF: s_axi_rdata <= {30'h00000000, ctrl_r};
					`IFM_STATUS_OFF: s_axi_rdata <= {29'h00000000, reject_r, run_sync,
						duplicate_assignment_error};
					`IFM_TERM_SEL_OFF: s_axi_rdata <= {26'h0000000, term_two_select_r};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `IFM_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // ifm_mapper
`default_nettype wire

//--- core/ifm_sync.v
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser for a pin level
module ifm_sync (
	// Clock and enable
	input wire mclk,
	input wire reset,
	input wire ce,
	// Data
	input wire din,
	output reg dout
);
	reg meta_r; // First stage, read only by dout
	// Shift through two flops
	always @(posedge mclk) begin
		if (reset) begin
			meta_r <= 1'b0;
			dout <= 1'b0;
		end else if (ce) begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule // ifm_sync
`default_nettype wire

//--- tb/ifm_mapper_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the mapper
module ifm_mapper_chk #(
	parameter NFUNC = 38
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Function outputs
	input wire logic [NFUNC-1:0] func_active,
	input wire logic servo_enable,
	input wire logic fault_warning_reset,
	input wire logic forward_limit_switch,
	input wire logic emergency_halt,
	input wire logic clear_position_deviation,
	input wire logic pulse_input_block
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// Write address accepted
	sequence aw_take;
		s_axi_awvalid && s_axi_awready;
	endsequence
	// Answer held until taken
	sequence r_held;
		s_axi_rvalid && $stable(s_axi_rdata);
	endsequence
	wresp_due_a: assert property (aw_take |-> ##[1:6] s_axi_bvalid)
		else $error("write response late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> r_held)
		else $error("read answer changed");
	// Reset itself must clear the outputs, so no disable here
	reset_clear_a: assert property (disable iff (1'b0) reset |=> func_active == 0)
		else $error("functions live after reset");
	code_none_a: assert property (!func_active[0])
		else $error("no-function slot active");
	servo_fault_a: assert property (servo_enable == func_active[1]
		&& fault_warning_reset == func_active[2])
		else $error("servo or fault reset misdecoded");
	fwd_limit_a: assert property (forward_limit_switch == func_active[14])
		else $error("forward limit misdecoded");
	halt_group_a: assert property ({emergency_halt, clear_position_deviation,
		pulse_input_block} == {func_active[34], func_active[35], func_active[37]})
		else $error("halt, clear or block misdecoded");
endmodule // ifm_mapper_chk
bind ifm_mapper ifm_mapper_chk #(.NFUNC(NFUNC)) i_ifm_mapper_chk (.mclk, .reset, .s_axi_awvalid,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.func_active, .servo_enable, .fault_warning_reset, .forward_limit_switch, .emergency_halt,
	.clear_position_deviation, .pulse_input_block);
`default_nettype wire

//--- tb/ifm_mapper_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ifm_map.vh"
module ifm_mapper_tb;
	// Stimulus, all given a value at time zero
	logic mclk = 1'h0, reset = 1'h1, ce = 1'h1, drive_running = 1'h0;
	logic close_one = 1'h0, close_two = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	// Design outputs
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	logic [37:0] func_active;
	logic servo_enable, fault_warning_reset, forward_limit_switch, emergency_halt;
	logic clear_position_deviation, pulse_input_block, duplicate_assignment_error;
	wire input_terminal_one, input_terminal_two;
	integer mismatches = 0, cmp_count = 0, i;
	logic [5:0] codes [0:5] = '{6'h00, 6'h01, 6'h02, 6'h22, 6'h23, 6'h25};
	initial forever #50 mclk = ~mclk;
	ifm_switch_model i_ifm_switch_model (.mclk, .close_one, .close_two,
		.term_one(input_terminal_one), .term_two(input_terminal_two));
	ifm_mapper i_ifm_mapper (.mclk, .reset, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .input_terminal_one, .input_terminal_two, .drive_running,
		.func_active, .servo_enable, .fault_warning_reset, .forward_limit_switch, .emergency_halt,
		.clear_position_deviation, .pulse_input_block, .duplicate_assignment_error);
	task stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input string nm, input [37:0] exp, input [37:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Bounded wait ran out: count it and close the run
	task hang;
		mismatches++;
		$display("CHECK FAILED bus answer expected within 40 cycles seen none");
		stop_test;
	endtask
	// Response ready is raised late on purpose so the hold checks get exercised
	task wr(input [7:0] a, input [31:0] d);
		integer n;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready) begin
				rsp = s_axi_bresp;
				s_axi_bready <= 1'h0;
				n = 99;
			end else if (s_axi_bvalid) s_axi_bready <= 1'h1;
		end
		if (n == 40) hang;
	endtask
	task rdw(input [7:0] a);
		integer n;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && s_axi_rready) begin
				rd = s_axi_rdata;
				rsp = s_axi_rresp;
				s_axi_rready <= 1'h0;
				n = 99;
			end else if (s_axi_rvalid) s_axi_rready <= 1'h1;
		end
		if (n == 40) hang;
	endtask
	// Reset values, and the default selection follows terminal one
	task t_reset;
		rdw(`IFM_MASK_HIGH_OFF);
		chk("mask reset", 38'h0, rd);
		rdw(`IFM_SEL_ONE_OFF);
		chk("select reset", 38'hE, rd);
		chk("functions idle", 38'h0, func_active);
		close_one <= 1'h1;
		// Model flop, two sync stages and the output flop, then one more edge to see it
		repeat (5) @(posedge mclk);
		chk("forward limit", 38'h1, forward_limit_switch);
		$display("test reset done");
	endtask
	// Each listed code (servo, fault reset, halt, clear, block) lands on its own slot, and none lands on no slot
	task t_codes;
		for (i = 0; i < 6; i++) begin
			wr(`IFM_SEL_ONE_OFF, codes[i]);
			repeat (4) @(posedge mclk);
			chk("decode", codes[i] == 0 ? 38'h0 : 38'h1 << codes[i], func_active);
		end
		$display("test codes done");
	endtask
	// Out-of-range code, write while running, unmapped place
	task t_refuse;
		wr(`IFM_SEL_ONE_OFF, 32'h3);
		wr(`IFM_SEL_ONE_OFF, 32'h26);
		rdw(`IFM_SEL_ONE_OFF);
		chk("range", 38'h3, rd);
		drive_running <= 1'h1;
		repeat (4) @(posedge mclk);
		wr(`IFM_SEL_ONE_OFF, 32'h1);
		rdw(`IFM_SEL_ONE_OFF);
		chk("running", 38'h3, rd);
		rdw(`IFM_STATUS_OFF);
		chk("status running", 38'h6, rd);
		drive_running <= 1'h0;
		rdw(8'h20);
		chk("unmapped", `IFM_RESP_SLVERR, rsp);
		wr(`IFM_STATUS_OFF, 32'h4);
		rdw(`IFM_STATUS_OFF);
		chk("status clear", 38'h0, rd);
		$display("test refuse done");
	endtask
	// Same code on both terminals, then distinct codes both live
	task t_dup;
		wr(`IFM_SEL_ONE_OFF, 32'h5);
		wr(`IFM_TERM_SEL_OFF, 32'h5);
		repeat (4) @(posedge mclk);
		chk("duplicate", 38'h1, duplicate_assignment_error);
		wr(`IFM_TERM_SEL_OFF, 32'h6);
		close_two <= 1'h1;
		repeat (5) @(posedge mclk);
		chk("duplicate off", 38'h0, duplicate_assignment_error);
		chk("two terminals", 38'h60, func_active);
		// Enable low must hold every output although terminal two opens
		ce <= 1'h0;
		close_two <= 1'h0;
		repeat (5) @(posedge mclk);
		chk("frozen", 38'h60, func_active);
		ce <= 1'h1;
		repeat (5) @(posedge mclk);
		chk("thawed", 38'h20, func_active);
		$display("test duplicate done");
	endtask
	// Mask stored in binary; live only after a power cycle, which reset stands for here
	task t_mask;
		wr(`IFM_SEL_ONE_OFF, 32'h0);
		wr(`IFM_TERM_SEL_OFF, 32'h0);
		wr(`IFM_MASK_HIGH_OFF, 65535);
		rdw(`IFM_MASK_HIGH_OFF);
		chk("mask value", 38'hFFFF, rd);
		repeat (4) @(posedge mclk);
		chk("mask deferred", 38'h0, func_active);
		reset <= 1'h1;
		repeat (2) @(posedge mclk);
		reset <= 1'h0;
		rdw(`IFM_MASK_HIGH_OFF);
		chk("mask after reset", 38'hFFFF, rd);
		repeat (2) @(posedge mclk);
		chk("mask live", 38'h1FFFE4000, func_active);
		// Terminal one opened first, then mapped onto masked function 17
		close_one <= 1'h0;
		wr(`IFM_SEL_ONE_OFF, 32'h11);
		repeat (5) @(posedge mclk);
		chk("terminal over mask", 38'h1FFFC0000, func_active);
		$display("test mask done");
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		reset <= 1'h0;
		t_reset;
		t_codes;
		t_refuse;
		t_dup;
		t_mask;
		stop_test;
	end
endmodule // ifm_mapper_tb
`default_nettype wire

//--- tb/ifm_switch_model.sv
`timescale 1ns/10ps
`default_nettype none
// External contacts feeding the two input terminals
module ifm_switch_model (
	// Clock
	input wire logic mclk,
	// Commanded contact states
	input wire logic close_one,
	input wire logic close_two,
	// Terminal pins
	output logic term_one,
	output logic term_two
);
	// Steady levels only, never pulses, so masked functions see no edges
	always @(posedge mclk) begin
		term_one <= close_one;
		term_two <= close_two;
	end
endmodule // ifm_switch_model
`default_nettype wire
